// ---- gpio_pkg.sv ----
// Shared constants for the dual eight-bit GPIO ports and their pin sharing.
package gpio_pkg;
    // Port width and register reset values.
    localparam int unsigned PORT_WIDTH = 8;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [7:0] SYSCTL_RST = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hff;
    // System-control field: set to release the test port pins to GPIO.
    localparam int unsigned SYSCTL_JTAG_DIS = 0;
    // Port 0 shared pin positions.
    localparam int unsigned P0_RX_MOSI = 0;
    localparam int unsigned P0_TX_MISO = 1;
    localparam int unsigned P0_SCL_SCLK = 2;
    localparam int unsigned P0_SDA_SSEL = 3;
    localparam int unsigned P0_TMR_A = 4;
    localparam int unsigned P0_TMR_B = 5;
    localparam int unsigned EXT_IRQ_COUNT = 6;
    // Serial peripheral line order within its four-bit vectors.
    localparam int unsigned SPI_MOSI = 0;
    localparam int unsigned SPI_MISO = 1;
    localparam int unsigned SPI_SCLK = 2;
    localparam int unsigned SPI_SSEL = 3;
    // Port 1 test port pin positions.
    localparam int unsigned P1_TCK = 4;
    localparam int unsigned P1_TDI = 5;
    localparam int unsigned P1_TMS = 6;
    localparam int unsigned P1_TDO = 7;
endpackage : gpio_pkg

// ---- pinmux_if.sv ----
// Special-function override bundle between the pin mux and one port's pin logic.
`timescale 1ns/1ps
`default_nettype none
interface pinmux_if #(
    parameter int unsigned WIDTH = 8
);
    logic [WIDTH-1:0] sel;
    logic [WIDTH-1:0] drv;
    logic [WIDTH-1:0] oe;
    logic [WIDTH-1:0] pu;
    logic [WIDTH-1:0] lvl;
    modport mux (output sel, output drv, output oe, output pu, input lvl);
    modport port (input sel, input drv, input oe, input pu, output lvl);
endinterface : pinmux_if
`default_nettype wire

// ---- port_pins.sv ----
// One GPIO port: direction and output registers, input synchroniser, pad drivers.
`timescale 1ns/1ps
`default_nettype none
module port_pins #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register writes.
    input wire logic dir_wr_i,
    input wire logic [WIDTH-1:0] dir_data_i,
    input wire logic out_wr_i,
    input wire logic [WIDTH-1:0] out_data_i,
    // Register readback.
    output logic [WIDTH-1:0] direction_o,
    output logic [WIDTH-1:0] output_level_o,
    output logic [WIDTH-1:0] input_level_o,
    // Pads.
    input wire logic [WIDTH-1:0] pad_i,
    output logic [WIDTH-1:0] pad_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] pullup_o,
    // Special-function override.
    pinmux_if.port mux
);
    logic [WIDTH-1:0] dir_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Refuse a port with no pins.
    if (WIDTH < 1 || WIDTH > gpio_pkg::PORT_WIDTH) begin : g_width_chk
        $error("port_pins: WIDTH out of range");
    end

    // Direction register; zero after reset keeps every pin an input.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dir_ff <= gpio_pkg::DIR_RST[WIDTH-1:0];
        end else if (dir_wr_i) begin
            dir_ff <= dir_data_i;
        end
    end

    // Output level register; zero after reset also keeps the pullups off.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_ff <= gpio_pkg::OUT_RST[WIDTH-1:0];
        end else if (out_wr_i) begin
            out_ff <= out_data_i;
        end
    end

    // Two-stage synchroniser; pins are asynchronous to the core clock.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pad_i;
            sync_ff <= meta_ff;
        end
    end

    assign direction_o = dir_ff;
    assign output_level_o = out_ff;
    // The pin is sampled whatever its direction, so software can read back a driven pin.
    assign input_level_o = sync_ff;
    assign mux.lvl = sync_ff;

    // Per pin, a selected special function replaces the GPIO driver and pullup.
    // In GPIO mode an input whose output bit is high gets its weak pullup.
    for (genvar b = 0; b < WIDTH; b++) begin : g_pin
        assign pad_oe_o[b] = mux.sel[b] ? mux.oe[b] : dir_ff[b];
        assign pad_o[b] = mux.sel[b] ? mux.drv[b] : out_ff[b];
        assign pullup_o[b] = mux.sel[b] ? mux.pu[b] : (~dir_ff[b] & out_ff[b]);
    end
endmodule : port_pins
`default_nettype wire

// ---- gpio_ports.sv ----
// Two eight-bit GPIO ports with special-function sharing and the test port default.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Port 0 pins use direction, output and input registers.
// - Port 1 pins use their own direction, output and input registers.
// - After reset port 0 pins float: no drive, no pullup.
// - A shared function takes a pin only once software enables it.
// - After reset port 1 test pins belong to the test port, pullups on.
// - A system-control bit disables the test port, returning pins to GPIO.
// - Port 0 bit 0 shares USART receive, SPI MOSI, external interrupt 0.
// - Port 0 bit 1 shares USART transmit, SPI MISO, external interrupt 1.
// - Port 0 bit 2 shares first I2C clock, SPI clock, external interrupt 2.
// - Port 0 bit 3 shares first I2C data, SPI select, external interrupt 3.
// - Port 0 bit 4 shares timer B line A and external interrupt 4.
// - Port 0 bit 5 shares timer B line B and external interrupt 5.
// - Test data output pin is pulled-up input; drives only in shift states.
module gpio_ports (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Port 0 register writes and readback.
    input wire logic port0_direction_wr_i,
    input wire logic [7:0] port0_direction_data_i,
    input wire logic port0_output_level_wr_i,
    input wire logic [7:0] port0_output_level_data_i,
    output logic [7:0] port0_direction_o,
    output logic [7:0] port0_output_level_o,
    output logic [7:0] port0_input_level_o,
    // Port 1 register writes and readback.
    input wire logic port1_direction_wr_i,
    input wire logic [7:0] port1_direction_data_i,
    input wire logic port1_output_level_wr_i,
    input wire logic [7:0] port1_output_level_data_i,
    output logic [7:0] port1_direction_o,
    output logic [7:0] port1_output_level_o,
    output logic [7:0] port1_input_level_o,
    // System control register.
    input wire logic system_control_wr_i,
    input wire logic [7:0] system_control_data_i,
    output logic [7:0] system_control_o,
    // Port 0 pads.
    input wire logic [7:0] port0_pad_i,
    output logic [7:0] port0_pad_o,
    output logic [7:0] port0_pad_oe_o,
    output logic [7:0] port0_pullup_o,
    // Port 1 pads.
    input wire logic [7:0] port1_pad_i,
    output logic [7:0] port1_pad_o,
    output logic [7:0] port1_pad_oe_o,
    output logic [7:0] port1_pullup_o,
    // USART.
    input wire logic usart_enable_i,
    input wire logic usart_transmit_line_i,
    output logic usart_receive_line_o,
    // SPI, lines ordered MOSI, MISO, SCLK, SSEL.
    input wire logic spi_enable_i,
    input wire logic [3:0] spi_out_i,
    input wire logic [3:0] spi_oe_i,
    output logic [3:0] spi_in_o,
    // First I2C port, open drain.
    input wire logic i2c0_enable_i,
    input wire logic first_i2c_clock_line_low_i,
    input wire logic first_i2c_data_line_low_i,
    output logic first_i2c_clock_line_o,
    output logic first_i2c_data_line_o,
    // Timer B.
    input wire logic timer_b_enable_i,
    input wire logic timer_b_line_a_i,
    input wire logic timer_b_line_a_oe_i,
    input wire logic timer_b_line_b_i,
    input wire logic timer_b_line_b_oe_i,
    output logic timer_b_line_a_o,
    output logic timer_b_line_b_o,
    // External interrupt inputs.
    input wire logic [5:0] ext_irq_enable_i,
    output logic ext_irq_input_zero_o,
    output logic ext_irq_input_one_o,
    output logic ext_irq_input_two_o,
    output logic ext_irq_input_three_o,
    output logic ext_irq_input_four_o,
    output logic ext_irq_input_five_o,
    // Test access port.
    input wire logic tap_shift_i,
    input wire logic tap_data_out_i,
    output logic jtag_enabled_o,
    output logic tck_o,
    output logic tdi_o,
    output logic tms_o
);
    pinmux_if #(.WIDTH(gpio_pkg::PORT_WIDTH)) p0 ();
    pinmux_if #(.WIDTH(gpio_pkg::PORT_WIDTH)) p1 ();

    logic [7:0] system_control_ff;
    logic [5:0] irq_ff;
    logic jtag_en;

    port_pins #(.WIDTH(gpio_pkg::PORT_WIDTH)) u_port0 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .dir_wr_i(port0_direction_wr_i),
        .dir_data_i(port0_direction_data_i),
        .out_wr_i(port0_output_level_wr_i),
        .out_data_i(port0_output_level_data_i),
        .direction_o(port0_direction_o),
        .output_level_o(port0_output_level_o),
        .input_level_o(port0_input_level_o),
        .pad_i(port0_pad_i),
        .pad_o(port0_pad_o),
        .pad_oe_o(port0_pad_oe_o),
        .pullup_o(port0_pullup_o),
        .mux(p0.port)
    );

    port_pins #(.WIDTH(gpio_pkg::PORT_WIDTH)) u_port1 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .dir_wr_i(port1_direction_wr_i),
        .dir_data_i(port1_direction_data_i),
        .out_wr_i(port1_output_level_wr_i),
        .out_data_i(port1_output_level_data_i),
        .direction_o(port1_direction_o),
        .output_level_o(port1_output_level_o),
        .input_level_o(port1_input_level_o),
        .pad_i(port1_pad_i),
        .pad_o(port1_pad_o),
        .pad_oe_o(port1_pad_oe_o),
        .pullup_o(port1_pullup_o),
        .mux(p1.port)
    );

    // System control; a cleared disable bit after reset leaves the test port in charge.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            system_control_ff <= gpio_pkg::SYSCTL_RST;
        end else if (system_control_wr_i) begin
            system_control_ff <= system_control_data_i;
        end
    end
    assign system_control_o = system_control_ff;
    assign jtag_en = ~system_control_ff[gpio_pkg::SYSCTL_JTAG_DIS];
    assign jtag_enabled_o = jtag_en;

    // Port 0 sharing. The USART wins over the SPI on bits 0 and 1, the I2C wins
    // over the SPI on bits 2 and 3, so a misconfigured pair never fights on a pin.
    // Interrupt inputs only listen, so they never take the driver away from GPIO.
    always_comb begin
        p0.sel = '0;
        p0.drv = '0;
        p0.oe = '0;
        p0.pu = '0;
        if (usart_enable_i) begin
            p0.sel[gpio_pkg::P0_RX_MOSI] = 1'b1;
        end else if (spi_enable_i) begin
            p0.sel[gpio_pkg::P0_RX_MOSI] = 1'b1;
            p0.drv[gpio_pkg::P0_RX_MOSI] = spi_out_i[gpio_pkg::SPI_MOSI];
            p0.oe[gpio_pkg::P0_RX_MOSI] = spi_oe_i[gpio_pkg::SPI_MOSI];
        end
        if (usart_enable_i) begin
            p0.sel[gpio_pkg::P0_TX_MISO] = 1'b1;
            p0.drv[gpio_pkg::P0_TX_MISO] = usart_transmit_line_i;
            p0.oe[gpio_pkg::P0_TX_MISO] = 1'b1;
        end else if (spi_enable_i) begin
            p0.sel[gpio_pkg::P0_TX_MISO] = 1'b1;
            p0.drv[gpio_pkg::P0_TX_MISO] = spi_out_i[gpio_pkg::SPI_MISO];
            p0.oe[gpio_pkg::P0_TX_MISO] = spi_oe_i[gpio_pkg::SPI_MISO];
        end
        if (i2c0_enable_i) begin
            p0.sel[gpio_pkg::P0_SCL_SCLK] = 1'b1;
            p0.oe[gpio_pkg::P0_SCL_SCLK] = first_i2c_clock_line_low_i;
            p0.sel[gpio_pkg::P0_SDA_SSEL] = 1'b1;
            p0.oe[gpio_pkg::P0_SDA_SSEL] = first_i2c_data_line_low_i;
        end else if (spi_enable_i) begin
            p0.sel[gpio_pkg::P0_SCL_SCLK] = 1'b1;
            p0.drv[gpio_pkg::P0_SCL_SCLK] = spi_out_i[gpio_pkg::SPI_SCLK];
            p0.oe[gpio_pkg::P0_SCL_SCLK] = spi_oe_i[gpio_pkg::SPI_SCLK];
            p0.sel[gpio_pkg::P0_SDA_SSEL] = 1'b1;
            p0.drv[gpio_pkg::P0_SDA_SSEL] = spi_out_i[gpio_pkg::SPI_SSEL];
            p0.oe[gpio_pkg::P0_SDA_SSEL] = spi_oe_i[gpio_pkg::SPI_SSEL];
        end
        if (timer_b_enable_i) begin
            p0.sel[gpio_pkg::P0_TMR_A] = 1'b1;
            p0.drv[gpio_pkg::P0_TMR_A] = timer_b_line_a_i;
            p0.oe[gpio_pkg::P0_TMR_A] = timer_b_line_a_oe_i;
            p0.sel[gpio_pkg::P0_TMR_B] = 1'b1;
            p0.drv[gpio_pkg::P0_TMR_B] = timer_b_line_b_i;
            p0.oe[gpio_pkg::P0_TMR_B] = timer_b_line_b_oe_i;
        end
    end

    // Port 1 test pins: pulled-up inputs, with the data output driven only while shifting.
    always_comb begin
        p1.sel = '0;
        p1.drv = '0;
        p1.oe = '0;
        p1.pu = '0;
        if (jtag_en) begin
            p1.sel[gpio_pkg::P1_TDO:gpio_pkg::P1_TCK] = 4'hf;
            p1.pu[gpio_pkg::P1_TDO:gpio_pkg::P1_TCK] = 4'hf;
            p1.drv[gpio_pkg::P1_TDO] = tap_data_out_i;
            p1.oe[gpio_pkg::P1_TDO] = tap_shift_i;
        end
    end

    // Levels handed to peripherals are registered; a disabled function sees its idle level.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            usart_receive_line_o <= 1'b1;
            spi_in_o <= '0;
            first_i2c_clock_line_o <= 1'b1;
            first_i2c_data_line_o <= 1'b1;
            timer_b_line_a_o <= 1'b0;
            timer_b_line_b_o <= 1'b0;
        end else begin
            usart_receive_line_o <= ~usart_enable_i | p0.lvl[gpio_pkg::P0_RX_MOSI];
            spi_in_o <= spi_enable_i ? p0.lvl[gpio_pkg::P0_SDA_SSEL:gpio_pkg::P0_RX_MOSI] : 4'h0;
            first_i2c_clock_line_o <= ~i2c0_enable_i | p0.lvl[gpio_pkg::P0_SCL_SCLK];
            first_i2c_data_line_o <= ~i2c0_enable_i | p0.lvl[gpio_pkg::P0_SDA_SSEL];
            timer_b_line_a_o <= timer_b_enable_i & p0.lvl[gpio_pkg::P0_TMR_A];
            timer_b_line_b_o <= timer_b_enable_i & p0.lvl[gpio_pkg::P0_TMR_B];
        end
    end

    // Interrupt inputs follow the low six pins whenever enabled.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            irq_ff <= '0;
        end else begin
            irq_ff <= ext_irq_enable_i & p0.lvl[gpio_pkg::EXT_IRQ_COUNT-1:0];
        end
    end
    assign ext_irq_input_zero_o = irq_ff[0];
    assign ext_irq_input_one_o = irq_ff[1];
    assign ext_irq_input_two_o = irq_ff[2];
    assign ext_irq_input_three_o = irq_ff[3];
    assign ext_irq_input_four_o = irq_ff[4];
    assign ext_irq_input_five_o = irq_ff[5];

    // Test-port levels, gated so the controller sees idle inputs when released.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tck_o <= 1'b0;
            tdi_o <= 1'b1;
            tms_o <= 1'b1;
        end else begin
            tck_o <= jtag_en & p1.lvl[gpio_pkg::P1_TCK];
            tdi_o <= ~jtag_en | p1.lvl[gpio_pkg::P1_TDI];
            tms_o <= ~jtag_en | p1.lvl[gpio_pkg::P1_TMS];
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    reset_hiz_a: assert property (!$past(rst_n_i) |->
        port0_pad_oe_o == 8'h00 && port0_pullup_o == 8'h00)
        else $error("port 0 not floating after reset");
    dir_write_a: assert property (port0_direction_wr_i |=>
        port0_pad_oe_o[7:6] == $past(port0_direction_data_i[7:6]))
        else $error("port 0 direction write not applied");
    p1_gpio_a: assert property (!jtag_en |->
        port1_pad_oe_o[7:4] == port1_direction_o[7:4] && port1_pad_o == port1_output_level_o)
        else $error("port 1 not under GPIO when test port off");
    test_pins_a: assert property (jtag_en && !tap_shift_i |->
        !port1_pad_oe_o[7] && port1_pullup_o[7:4] == 4'hf)
        else $error("test pins not pulled-up inputs");
    sf_gate_a: assert property (!usart_enable_i && !spi_enable_i && !i2c0_enable_i |->
        port0_pad_oe_o[3:0] == port0_direction_o[3:0])
        else $error("function took pin before enable");
    usart_tx_a: assert property (usart_enable_i |->
        port0_pad_oe_o[1] && port0_pad_o[1] == usart_transmit_line_i)
        else $error("USART transmit not on bit 1");
    i2c_clk_a: assert property (i2c0_enable_i && first_i2c_clock_line_low_i |->
        port0_pad_oe_o[2] && !port0_pad_o[2])
        else $error("I2C clock not pulled low");
    timer_a_a: assert property (timer_b_enable_i |->
        port0_pad_oe_o[4] == timer_b_line_a_oe_i && port0_pad_o[4] == timer_b_line_a_i)
        else $error("timer line A not on bit 4");
    input_sync_a: assert property ($past(rst_n_i) && $past(rst_n_i, 2) |->
        port0_input_level_o == $past(port0_pad_i, 2))
        else $error("input level not two-stage synchronised");
    irq_follow_a: assert property (ext_irq_enable_i[0] |=>
        ext_irq_input_zero_o == $past(port0_input_level_o[0]))
        else $error("interrupt 0 does not follow pin");

    usart_on_c: cover property (usart_enable_i && port0_pad_oe_o[1]);
    jtag_off_c: cover property ($rose(system_control_o[gpio_pkg::SYSCTL_JTAG_DIS]));
    tdo_drive_c: cover property (jtag_en && tap_shift_i ##1 !tap_shift_i);
    gpio_out_c: cover property (port0_direction_wr_i ##1 port0_pad_oe_o != 8'h00);
endmodule : gpio_ports
`default_nettype wire

// ---- board_pads.sv ----
// Board-side model of one eight-bit port: resolves each pin from device and board drive.
`timescale 1ns/1ps
`default_nettype none
module board_pads (
    // Clock for the float pattern.
    input wire logic mclk_i,
    // Device side of the pads.
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    // Board side drive and its enables.
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    // Resolved pin level.
    output logic [7:0] lvl_o
);
    logic [7:0] float_ff = 8'h5a;
    // A released pin holds no value, so it shows a pattern that flips every cycle.
    always @(posedge mclk_i) begin
        float_ff <= ~float_ff;
    end
    // The device wins over the board, whose drive sits behind a series resistor.
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_i)
        | (~oe_i & ~ext_en_i & (pu_i | float_ff));
endmodule : board_pads
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the dual GPIO ports and their shared pin functions.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {int unsigned sel; logic [7:0] exp; logic [7:0] msk;} note_t;
    note_t notes[$];
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] seed = 8'h38;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, system_control_wr_i = 1'b0;
    logic port0_direction_wr_i = 1'b0, port0_output_level_wr_i = 1'b0;
    logic port1_direction_wr_i = 1'b0, port1_output_level_wr_i = 1'b0;
    logic [7:0] port0_direction_data_i = 8'h00, port0_output_level_data_i = 8'h00;
    logic [7:0] port1_direction_data_i = 8'h00, port1_output_level_data_i = 8'h00;
    logic [7:0] system_control_data_i = 8'h00, port0_ext = 8'h00, port1_ext = 8'h00;
    logic usart_enable_i = 1'b0, usart_transmit_line_i = 1'b0, spi_enable_i = 1'b0;
    logic [3:0] spi_out_i = 4'h0, spi_oe_i = 4'h0;
    logic i2c0_enable_i = 1'b0, first_i2c_clock_line_low_i = 1'b0;
    logic first_i2c_data_line_low_i = 1'b0, timer_b_enable_i = 1'b0;
    logic timer_b_line_a_i = 1'b0, timer_b_line_a_oe_i = 1'b0;
    logic timer_b_line_b_i = 1'b0, timer_b_line_b_oe_i = 1'b0;
    logic [5:0] ext_irq_enable_i = 6'h00;
    logic tap_shift_i = 1'b0, tap_data_out_i = 1'b0;
    logic [7:0] port0_direction_o, port0_output_level_o, port0_input_level_o;
    logic [7:0] port1_direction_o, port1_output_level_o, port1_input_level_o;
    logic [7:0] system_control_o, port0_pad_i, port0_pad_o, port0_pad_oe_o, port0_pullup_o;
    logic [7:0] port1_pad_i, port1_pad_o, port1_pad_oe_o, port1_pullup_o;
    logic usart_receive_line_o, first_i2c_clock_line_o, first_i2c_data_line_o;
    logic [3:0] spi_in_o;
    logic timer_b_line_a_o, timer_b_line_b_o, ext_irq_input_zero_o, ext_irq_input_one_o;
    logic ext_irq_input_two_o, ext_irq_input_three_o, ext_irq_input_four_o;
    logic ext_irq_input_five_o, jtag_enabled_o, tck_o, tdi_o, tms_o;
    gpio_ports i_gpio_ports (.mclk_i, .rst_n_i, .port0_direction_wr_i, .port0_direction_data_i,
        .port0_output_level_wr_i, .port0_output_level_data_i, .port0_direction_o,
        .port0_output_level_o, .port0_input_level_o, .port1_direction_wr_i,
        .port1_direction_data_i, .port1_output_level_wr_i, .port1_output_level_data_i,
        .port1_direction_o, .port1_output_level_o, .port1_input_level_o, .system_control_wr_i,
        .system_control_data_i, .system_control_o, .port0_pad_i, .port0_pad_o, .port0_pad_oe_o,
        .port0_pullup_o, .port1_pad_i, .port1_pad_o, .port1_pad_oe_o, .port1_pullup_o,
        .usart_enable_i, .usart_transmit_line_i, .usart_receive_line_o, .spi_enable_i,
        .spi_out_i, .spi_oe_i, .spi_in_o, .i2c0_enable_i, .first_i2c_clock_line_low_i,
        .first_i2c_data_line_low_i, .first_i2c_clock_line_o, .first_i2c_data_line_o,
        .timer_b_enable_i, .timer_b_line_a_i, .timer_b_line_a_oe_i, .timer_b_line_b_i,
        .timer_b_line_b_oe_i, .timer_b_line_a_o, .timer_b_line_b_o, .ext_irq_enable_i,
        .ext_irq_input_zero_o, .ext_irq_input_one_o, .ext_irq_input_two_o,
        .ext_irq_input_three_o, .ext_irq_input_four_o, .ext_irq_input_five_o, .tap_shift_i,
        .tap_data_out_i, .jtag_enabled_o, .tck_o, .tdi_o, .tms_o);
    board_pads i_board_pads0 (.mclk_i, .drv_i(port0_pad_o), .oe_i(port0_pad_oe_o),
        .pu_i(port0_pullup_o), .ext_i(port0_ext), .ext_en_i(8'hff), .lvl_o(port0_pad_i));
    board_pads i_board_pads1 (.mclk_i, .drv_i(port1_pad_o), .oe_i(port1_pad_oe_o),
        .pu_i(port1_pullup_o), .ext_i(port1_ext), .ext_en_i(8'hff), .lvl_o(port1_pad_i));
    // Free-running core clock at 20 MHz.
    always #25 mclk_i = ~mclk_i;
    // Eight-bit feedback shift register for the random stimulus.
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : rnd
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    task automatic note(input int unsigned sel, input logic [7:0] exp, input logic [7:0] msk);
        notes.push_back('{sel, exp, msk});
    endtask : note
    // One write cycle for any mix of the five registers; the strobes drop a cycle later.
    task automatic wr(input logic [4:0] m, input logic [7:0] d0, d1, o0, o1, sc);
        @(posedge mclk_i);
        {port0_direction_wr_i, port1_direction_wr_i, port0_output_level_wr_i,
            port1_output_level_wr_i, system_control_wr_i} <= m;
        port0_direction_data_i <= d0;
        port1_direction_data_i <= d1;
        port0_output_level_data_i <= o0;
        port1_output_level_data_i <= o1;
        system_control_data_i <= sc;
        @(posedge mclk_i);
        {port0_direction_wr_i, port1_direction_wr_i, port0_output_level_wr_i,
            port1_output_level_wr_i, system_control_wr_i} <= 5'h00;
    endtask : wr
    function automatic logic [7:0] observe(input int unsigned sel);
        case (sel)
            0: return port0_direction_o;
            1: return port0_output_level_o;
            2: return port0_input_level_o;
            3: return port1_direction_o;
            4: return port1_output_level_o;
            5: return port1_input_level_o;
            6: return system_control_o;
            7: return port0_pad_oe_o;
            8: return port0_pullup_o;
            9: return port1_pad_oe_o;
            10: return port1_pullup_o;
            11: return port0_pad_o;
            12: return {2'b00, ext_irq_input_five_o, ext_irq_input_four_o, ext_irq_input_three_o,
                ext_irq_input_two_o, ext_irq_input_one_o, ext_irq_input_zero_o};
            13: return {jtag_enabled_o, tck_o, tdi_o, tms_o, spi_in_o};
            14: return {3'b000, usart_receive_line_o, first_i2c_clock_line_o,
                first_i2c_data_line_o, timer_b_line_a_o, timer_b_line_b_o};
            default: return port1_pad_o;
        endcase
    endfunction : observe
    // Outputs are settled at the falling edge, so all pending notes are judged there.
    always @(negedge mclk_i) begin
        while (notes.size() > 0) begin
            n_compared++;
            if ((observe(notes[0].sel) & notes[0].msk) !== (notes[0].exp & notes[0].msk)) begin
                n_mismatch++;
                $display("mismatch at %0t sel %0d expected %h got %h", $time, notes[0].sel,
                    notes[0].exp & notes[0].msk, observe(notes[0].sel) & notes[0].msk);
            end
            void'(notes.pop_front());
        end
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // A hung sequence is cut short and counted as a failure.
    initial begin
        tick(5000);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        logic [7:0] d0, o0, d1, o1, x0, x1, e;
        tick(12);
        rst_n_i <= 1'b1;
        note(7, 8'h00, 8'hff);
        note(8, 8'h00, 8'hff);
        note(10, 8'hf0, 8'hff);
        note(9, 8'h00, 8'hff);
        note(13, 8'h80, 8'h80);
        // Random GPIO traffic while the USART, SPI, I2C and timer stay disabled; interrupt enables are random and the test port stays on.
        for (int i = 0; i < 8; i++) begin
            d0 = rnd();
            o0 = rnd();
            d1 = rnd();
            o1 = rnd();
            x0 = rnd();
            x1 = rnd();
            e = rnd();
            {spi_oe_i, spi_out_i} <= x1;
            {timer_b_line_a_oe_i, timer_b_line_b_oe_i, usart_transmit_line_i} <= e[7:5];
            port0_ext <= x0;
            port1_ext <= x1;
            ext_irq_enable_i <= e[5:0];
            wr(5'h1e, d0, d1, o0, o1, 8'h00);
            note(0, d0, 8'hff);
            note(1, o0, 8'hff);
            note(3, d1, 8'hff);
            note(4, o1, 8'hff);
            note(7, d0, 8'hff);
            note(8, ~d0 & o0, 8'hff);
            note(11, o0, d0);
            note(9, d1, 8'h0f);
            tick(2);
            note(2, (d0 & o0) | (~d0 & x0), 8'hff);
            note(5, (d1 & o1 & 8'h0f) | (~(d1 & 8'h0f) & x1), 8'hff);
            tick(1);
            note(12, e & ((d0 & o0) | (~d0 & x0)), 8'h3f);
            note(13, {1'b1, x1[4], x1[5], x1[6], 4'h0}, 8'hff);
            note(14, 8'h1c, 8'hff);
        end
        usart_enable_i <= 1'b1;
        tick(4);
        note(7, 8'h02, 8'h03);
        note(11, {6'h00, e[5], 1'b0}, 8'h02);
        note(14, {3'b000, x0[0], 4'h0}, 8'h10);
        // Pad outputs are combinational, so hold the stimulus until they are judged.
        tick(1);
        usart_enable_i <= 1'b0;
        i2c0_enable_i <= 1'b1;
        {first_i2c_clock_line_low_i, first_i2c_data_line_low_i} <= 2'b10;
        tick(4);
        note(7, 8'h04, 8'h0c);
        note(14, {4'h0, 1'b0, x0[3], 2'b00}, 8'h0c);
        tick(1);
        i2c0_enable_i <= 1'b0;
        spi_enable_i <= 1'b1;
        tick(4);
        note(7, {4'h0, x1[7:4]}, 8'h0f);
        note(11, {4'h0, x1[3:0]}, {4'h0, x1[7:4]});
        note(13, {4'h0, (x1[7:4] & x1[3:0]) | (~x1[7:4] & x0[3:0])}, 8'h0f);
        tick(1);
        spi_enable_i <= 1'b0;
        timer_b_enable_i <= 1'b1;
        {timer_b_line_a_oe_i, timer_b_line_a_i, timer_b_line_b_oe_i} <= 3'b110;
        tick(4);
        note(7, 8'h10, 8'h30);
        note(11, 8'h10, 8'h10);
        note(14, {7'h00, x0[5]}, 8'h01);
        tick(1);
        timer_b_enable_i <= 1'b0;
        {tap_shift_i, tap_data_out_i} <= 2'b11;
        tick(2);
        note(9, 8'h80, 8'hf0);
        note(15, 8'h80, 8'h80);
        // Disabling the test port hands pins 4 to 7 back to the port 1 registers.
        wr(5'h01, d0, d1, o0, o1, 8'h01);
        note(6, 8'h01, 8'hff);
        note(13, 8'h00, 8'h80);
        note(9, d1, 8'hf0);
        note(10, ~d1 & o1, 8'hf0);
        tick(3);
        note(13, 8'h30, 8'hf0);
        // Second reset in mid-run.
        rst_n_i <= 1'b0;
        tick(2);
        note(6, 8'h00, 8'hff);
        note(8, 8'h00, 8'hff);
        note(10, 8'hf0, 8'hf0);
        rst_n_i <= 1'b1;
        tick(2);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
